// *** logic/program_sequencer.sv ***
/*
  Program sequencer: fetch addressing, alignment buffer, eight-stage
  line pipeline, predicate evaluation and sequencer control bits.
  Assumes an instruction memory bus with a req/ack handshake and APB.
*/
`timescale 1ns/100ps
`default_nettype none
module program_sequencer #(
  parameter int ADDR_W = 32,
  parameter int INSTR_W = 32
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       fetch_req,
  output logic [ADDR_W-1:0]          fetch_addr,
  input  wire logic                  fetch_ack,
  input  wire logic [4*INSTR_W-1:0]  fetch_data,
  input  wire logic                  boot_done,
  input  wire logic                  irq_entry,
  input  wire logic                  stall,
  input  wire logic                  branch_take,
  input  wire logic [ADDR_W-1:0]     branch_target,
  input  wire logic                  cache_hit,
  input  wire logic [ADDR_W-1:0]     cache_target,
  input  wire logic [31:0]           unit_flags,
  input  wire logic [3:0]            pin_in,
  output logic [3:0]                 pin_out,
  output logic [3:0]                 pin_oe,
  output logic                       supervisor_mode,
  output logic [1:0]                 timer_run,
  output logic [3:0]                 irq_level_sense,
  output logic                       branch_buffer_enable,
  output logic                       branch_buffer_lock,
  output logic                       core_reset,
  output logic [2:0]                 line_count,
  output logic [4*INSTR_W-1:0]       line_slots,
  output logic                       line_valid,
  output logic [sequencer_pkg::PIPE_STAGES-1:0] stage_valid,
  output logic                       line_done,
  output logic                       line_enable
);
  import sequencer_pkg::*;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire logic       access_ph = psel && penable;
  wire logic       setup_ph  = psel && !penable;
  wire logic       hit_ctrl  = (paddr == SEQ_CTRL_OFF);
  wire logic       hit_stat  = (paddr == SEQ_STATUS_OFF);
  wire logic       hit_sflag = (paddr == STATIC_FLAG_OFF);
  wire logic       hit_pstat = (paddr == PIPE_STATUS_OFF);
  wire logic       hit_cmd   = (paddr == PIPE_CMD_OFF);
  wire logic       wr_ctrl   = access_ph && pwrite && hit_ctrl;
  wire logic       wr_sflag  = access_ph && pwrite && hit_sflag;
  wire logic       wr_cmd    = access_ph && pwrite && hit_cmd;
  // Unmapped words answer with an error and read as zero
  wire logic       mapped    = hit_ctrl || hit_stat || hit_sflag || hit_pstat || hit_cmd;

  logic [31:0] control;
  logic [31:0] static_flag_register;
  logic [31:0] predicate_sel;
  logic [3:0]  pin_sync1;
  logic [3:0]  pin_sync2;
  logic [31:0] status_word;
  logic [31:0] pipe_word;
  logic [31:0] next_prdata;

  // Pins driven as outputs read as zero in the input field
  assign status_word = {12'h000, pin_sync2 & ~control[DIR_LSB +: 4], 15'h0000,
                        supervisor_mode};
  assign next_prdata = hit_ctrl  ? control :
                       hit_stat  ? status_word :
                       hit_sflag ? static_flag_register :
                       hit_pstat ? pipe_word :
                       hit_cmd   ? predicate_sel : 32'h00000000;

  // Zero-wait slave: answers in the first access cycle
  // Read data latched at setup so it stands through the access phase
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= setup_ph ? next_prdata : prdata;
      pready  <= setup_ph;
      pslverr <= setup_ph && !mapped;
    end
  end

  // ---------------------------------------------------------------
  // Control register and soft reset
  // ---------------------------------------------------------------
  logic [2:0] soft_cnt;
  logic [2:0] next_soft_cnt;
  wire logic  soft_rst = control[31] || (soft_cnt != 3'd0);

  // Counter stretches the one-shot request into a clean pulse
  assign next_soft_cnt = control[31]        ? 3'(SOFT_RST_CYC) :
                         (soft_cnt != 3'd0) ? soft_cnt - 3'd1  : 3'd0;
  // Control is kept across soft reset so software keeps its setup
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control <= CTRL_RESET;
    end else if (wr_ctrl && pready) begin
      // Bit 31 kept as a one-shot soft reset request, self clearing
      control <= (pwdata & CTRL_WMASK) | {pwdata[31], 31'h0};
    end else begin
      control[31] <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      soft_cnt   <= 3'd0;
      core_reset <= 1'b0;
    end else begin
      soft_cnt   <= next_soft_cnt;
      core_reset <= soft_rst;
    end
  end
  wire logic core_rst = !rst_n || soft_rst;

  // ---------------------------------------------------------------
  // Privilege mode with delayed effect
  // ---------------------------------------------------------------
  logic [MODE_LATENCY-1:0] mode_pipe;
  logic                    mode_wr_pend;
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      mode_pipe       <= '0;
      supervisor_mode <= 1'b0;
    end else begin
      mode_pipe <= {mode_pipe[MODE_LATENCY-2:0], wr_ctrl && pready};
      // Boot and interrupt entry outrank a pending write
      if (boot_done || irq_entry)
        supervisor_mode <= 1'b1;
      else if (mode_pipe[MODE_LATENCY-1])
        supervisor_mode <= control[MODE_BIT];
    end
  end
  assign mode_wr_pend = |mode_pipe;

  // ---------------------------------------------------------------
  // Timers, branch cache, interrupt sense, flag pins
  // ---------------------------------------------------------------
  // Plain mirrors of control, registered so each output leaves a flop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_run            <= 2'b00;
      irq_level_sense      <= 4'h0;
      branch_buffer_enable <= 1'b0;
      branch_buffer_lock   <= 1'b0;
    end else begin
      timer_run            <= {control[TMR1_BIT], control[TMR0_BIT]};
      irq_level_sense      <= control[EDGE_LSB +: 4];
      branch_buffer_enable <= control[BUF_EN_BIT];
      branch_buffer_lock   <= control[BUF_LOCK_BIT];
    end
  end

  // Flag pins: inputs pass two flops, drive trails its bit
  logic [3:0] drive_d1;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_sync1            <= 4'h0;
      pin_sync2            <= 4'h0;
      drive_d1             <= 4'h0;
      pin_out              <= 4'h0;
      pin_oe               <= 4'h0;
    end else begin
      pin_sync1            <= pin_in;
      pin_sync2            <= pin_sync1;
      // Two-stage path puts the pin 2 cycles behind the bit
      drive_d1             <= control[DRIVE_LSB +: 4];
      pin_out              <= drive_d1 & control[DIR_LSB +: 4];
      pin_oe               <= control[DIR_LSB +: 4];
    end
  end

  // ---------------------------------------------------------------
  // Static flags and predicate
  // ---------------------------------------------------------------
  // Selector: [5] inverts, [4:0] index, [6] picks static register
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      static_flag_register <= 32'h00000000;
      predicate_sel        <= 32'h00000000;
    end else begin
      if (wr_sflag && pready)
        static_flag_register <= pwdata;
      if (wr_cmd && pready)
        predicate_sel <= {25'h0, pwdata[6:0]};
    end
  end
  wire logic [4:0] flag_idx    = predicate_sel[4:0];
  wire logic       pick_static = predicate_sel[6];
  wire logic       pick_invert = predicate_sel[5];
  wire logic       flag_pick   = pick_static ? static_flag_register[flag_idx]
                                             : unit_flags[flag_idx];

  // Inversion is a plain XOR, so either polarity costs nothing
  wire logic       pred_true   = flag_pick ^ pick_invert;

  // ---------------------------------------------------------------
  // Fetch unit and program counter
  // ---------------------------------------------------------------
  fetch_state_t            fstate;
  logic [ADDR_W-1:0]       pc;
  logic [4*INSTR_W-1:0]    align_buf;
  logic                    align_full;
  logic [2:0]              slot_ptr;
  wire logic               drain = align_full && !stall;
  wire logic               quad_used;
  wire logic [ADDR_W-1:0]  next_pc = branch_take ? branch_target :
                                     cache_hit   ? cache_target : pc + ADDR_W'(LINE_MAX);

  always_ff @(posedge mclk) begin
    if (core_rst) begin
      fstate     <= FETCH_IDLE;
      fetch_req  <= 1'b0;
      fetch_addr <= '0;
      pc         <= '0;
    end else begin
      case (fstate)
        FETCH_IDLE: begin
          if (!align_full || quad_used) begin
            fetch_req  <= 1'b1;
            fetch_addr <= pc;
            fstate     <= FETCH_REQ;
          end
        end
        FETCH_REQ: begin
          // Request and address hold until memory acknowledges
          if (fetch_ack) begin
            fetch_req <= 1'b0;
            pc        <= next_pc;
            fstate    <= FETCH_WAIT;
          end
        end
        // Spare cycle lets the buffer settle before the next request
        FETCH_WAIT: fstate <= FETCH_IDLE;
        default: fstate <= FETCH_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Alignment buffer and line split
  // ---------------------------------------------------------------
  // Each slot's top bit marks the end of a line
  logic [2:0] len;
  always_comb begin
    len = 3'(LINE_MAX) - slot_ptr;
    for (int i = LINE_MAX - 1; i >= 0; i--) begin
      if (i >= int'(slot_ptr) && align_buf[i*INSTR_W + INSTR_W-1])
        len = 3'(i + 1) - slot_ptr;
    end
  end
  assign quad_used = drain && (slot_ptr + len == 3'(LINE_MAX));

  // A fresh quad only lands once the old one is used up
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      align_buf  <= '0;
      align_full <= 1'b0;
      slot_ptr   <= 3'd0;
    end else if (fstate == FETCH_REQ && fetch_ack) begin
      align_buf  <= fetch_data;
      align_full <= 1'b1;
      slot_ptr   <= 3'd0;
    end else if (drain) begin
      slot_ptr   <= quad_used ? 3'd0 : slot_ptr + len;
      align_full <= !quad_used;
    end
  end

  // ---------------------------------------------------------------
  // Instruction pipeline: F1 F2 F3 D I A EX1 EX2
  // ---------------------------------------------------------------
  // Opcode in bits [30:28] of the slot at slot_ptr below 5 marks unconditional ops
  wire logic [2:0] op_class = align_buf[slot_ptr*INSTR_W + 28 +: 3];
  wire logic       uncond   = op_class < 3'd5;
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      stage_valid <= '0;
      line_valid  <= 1'b0;
      line_count  <= 3'd0;
      line_slots  <= '0;
      line_done   <= 1'b0;
      line_enable <= 1'b0;
    end else if (!stall) begin
      // Stall freezes every stage so no line is lost or doubled
      // Shift one place per clock; exit after stage eight
      stage_valid <= {stage_valid[PIPE_STAGES-2:0], drain};
      line_done   <= stage_valid[PIPE_STAGES-1];
      line_valid  <= drain;
      line_count  <= drain ? len : 3'd0;
      line_slots  <= drain ? (align_buf >> (slot_ptr*INSTR_W)) : '0;
      line_enable <= drain && (uncond || pred_true);
    end else begin
      line_done <= 1'b0;
    end
  end

  // Debug view of fetch and pipeline state
  assign pipe_word = {12'h000, 1'b0, slot_ptr, mode_wr_pend, align_full,
                      fstate, 3'b000, stage_valid};
endmodule
`default_nettype wire

// *** logic/sequencer_pkg.sv ***
/*
  Constants for the program sequencer pipeline control block.
  Assumes a single 25 MHz clock and an APB register port.
*/
package sequencer_pkg;
  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam logic [7:0] SEQ_CTRL_OFF     = 8'h00;
  localparam logic [7:0] SEQ_STATUS_OFF   = 8'h04;
  localparam logic [7:0] STATIC_FLAG_OFF  = 8'h08;
  localparam logic [7:0] PIPE_STATUS_OFF  = 8'h0c;
  localparam logic [7:0] PIPE_CMD_OFF     = 8'h10;
  localparam logic [31:0] CTRL_RESET      = 32'h00000000;
  localparam logic [31:0] CTRL_WMASK      = 32'h0fff001f;
  // -----------------------------------------------------------------
  // Control field positions
  // -----------------------------------------------------------------
  localparam int MODE_BIT      = 0;
  localparam int BUF_EN_BIT    = 1;
  localparam int BUF_LOCK_BIT  = 2;
  localparam int TMR0_BIT      = 3;
  localparam int TMR1_BIT      = 4;
  localparam int EDGE_LSB      = 16;
  localparam int DIR_LSB       = 20;
  localparam int DRIVE_LSB     = 24;
  localparam int PIN_IN_LSB    = 16;
  // -----------------------------------------------------------------
  // Pipeline and timing
  // -----------------------------------------------------------------
  localparam int PIPE_STAGES   = 8;
  localparam int MODE_LATENCY  = 3;
  localparam int PIN_DELAY     = 2;
  localparam int LINE_MAX      = 4;
  localparam int SOFT_RST_CYC  = 4;
  typedef enum logic [2:0] {
    FETCH_IDLE = 3'b001,
    FETCH_REQ  = 3'b010,
    FETCH_WAIT = 3'b100
  } fetch_state_t;
endpackage

// *** test/mem_model.sv ***
/*
  Instruction memory model answering quad-word fetches.
  Assumes the sequencer holds fetch_req until it sees fetch_ack.
*/
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [2:0]   lat,
  input  wire logic         fetch_req,
  input  wire logic [31:0]  fetch_addr,
  output logic              fetch_ack,
  output logic [127:0]      fetch_data
);
  logic [2:0]  cnt;
  logic [31:0] w;
  // Odd quads carry conditional opcodes, even quads unconditional ones
  assign w = {1'b0, fetch_addr[2], 2'b11, fetch_addr[27:0]};
  // ------------------------------
  // Answer after lat wait cycles
  // ------------------------------
  always_ff @(posedge mclk) begin
    fetch_ack  <= 1'b0;
    fetch_data <= ~fetch_data;  // Idle bus never holds a stale quad
    if (!rst_n) begin
      cnt        <= 3'h0;
      fetch_data <= 128'h0;
    end else if (fetch_req && !fetch_ack) begin
      if (cnt == lat) begin
        cnt        <= 3'h0;
        fetch_ack  <= 1'b1;
        fetch_data <= {w | 32'h80000000, w, w | 32'h80000000, w};  // Two-slot lines
      end else begin
        cnt <= cnt + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/sequencer_sva.sv ***
/*
  Port checker for the program sequencer.
  Assumes it is bound onto program_sequencer, one clock mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module sequencer_sva
  import sequencer_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic                    mclk,
  input wire logic                    rst_n,
  input wire logic [7:0]              paddr,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    fetch_req,
  input wire logic [ADDR_W-1:0]       fetch_addr,
  input wire logic                    fetch_ack,
  input wire logic                    boot_done,
  input wire logic                    irq_entry,
  input wire logic                    stall,
  input wire logic [3:0]              pin_out,
  input wire logic [3:0]              pin_oe,
  input wire logic                    supervisor_mode,
  input wire logic [1:0]              timer_run,
  input wire logic                    core_reset,
  input wire logic [PIPE_STAGES-1:0]  stage_valid
);
  // ------------------------------
  // Helpers
  // ------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic        acc, ctl, ctl_wr, srst_wr, calm, mapped;
  logic [31:0] wr_val;
  assign acc     = psel && penable && pready;
  assign ctl     = acc && pwrite && paddr == SEQ_CTRL_OFF;
  assign ctl_wr  = ctl && !pwdata[31];
  assign srst_wr = ctl && pwdata[31];
  assign calm    = !boot_done && !irq_entry && !core_reset;
  assign mapped  = paddr inside {SEQ_CTRL_OFF, SEQ_STATUS_OFF, STATIC_FLAG_OFF,
                                 PIPE_STATUS_OFF, PIPE_CMD_OFF};
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_val <= 32'h0;
    end else if (ctl_wr) begin
      wr_val <= pwdata;
    end
  end
  // ------------------------------
  // Properties
  // ------------------------------
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing in access phase");
  refuse_map_a: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  resv_zero_a: assert property (acc && !pwrite && paddr == SEQ_CTRL_OFF |-> (prdata & ~CTRL_WMASK) == 32'h0)
    else $error("reserved control bits read nonzero");
  mode_lat_a: assert property (ctl_wr && calm ##1 calm[*3] |=> supervisor_mode == $past(pwdata[MODE_BIT], 4))
    else $error("mode bit not applied three cycles after write");
  boot_sup_a: assert property ((boot_done || irq_entry) && !core_reset |-> ##[1:2] supervisor_mode)
    else $error("supervisor mode not entered");
  pin_dir_a: assert property (ctl_wr |-> ##[1:3] pin_oe == wr_val[23:20])
    else $error("pin direction does not follow control");
  pin_drv_a: assert property (ctl_wr |-> ##[1:3] pin_out == (wr_val[27:24] & wr_val[23:20]))
    else $error("pin value does not follow control");
  timer_run_a: assert property (ctl_wr |-> ##[1:3] timer_run == wr_val[TMR1_BIT:TMR0_BIT])
    else $error("timer run bits do not follow control");
  fetch_hold_a: assert property (fetch_req && !fetch_ack && !core_reset && !srst_wr && !$past(srst_wr) |=> fetch_req && $stable(fetch_addr))
    else $error("fetch request dropped before answer");
  pipe_depth_a: assert property ((stage_valid[0] && !stall && !core_reset) ##1 (!stall && !core_reset)[*6] |=> stage_valid[PIPE_STAGES-1])
    else $error("line did not reach last stage");
endmodule
bind program_sequencer sequencer_sva #(.ADDR_W(ADDR_W)) sva_u (.mclk, .rst_n, .paddr, .psel,
  .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .fetch_req, .fetch_addr, .fetch_ack,
  .boot_done, .irq_entry, .stall, .pin_out, .pin_oe, .supervisor_mode, .timer_run, .core_reset,
  .stage_valid);
`default_nettype wire

// *** test/tb_top.sv ***
/*
  Testbench for the program sequencer over APB.
  Assumes mem_model on the fetch side and a 25 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sequencer_pkg::*;
  logic         mclk, rst_n, psel, penable, pwrite, pready, pslverr, err, fetch_req, fetch_ack;
  logic         boot_done, irq_entry, stall, supervisor_mode, branch_buffer_enable;
  logic         branch_buffer_lock, core_reset, line_valid, line_done, line_enable;
  logic [7:0]   paddr, stage_valid;
  logic [31:0]  pwdata, prdata, q, d, fetch_addr;
  logic [127:0] fetch_data, line_slots;
  logic [3:0]   pin_in, pin_out, pin_oe, irq_level_sense;
  logic [2:0]   line_count, lat;
  logic [1:0]   timer_run;
  int           failures, check_count, n, dn, m;
  logic         pe;
  always #20 mclk = ~mclk;
  program_sequencer dut_u (.mclk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .fetch_req, .fetch_addr, .fetch_ack, .fetch_data, .boot_done, .irq_entry,
    .stall, .branch_take(1'b0), .branch_target(32'h0), .cache_hit(1'b0), .cache_target(32'h0),
    .unit_flags(32'h0), .pin_in, .pin_out, .pin_oe, .supervisor_mode, .timer_run,
    .irq_level_sense, .branch_buffer_enable, .branch_buffer_lock, .core_reset, .line_count,
    .line_slots, .line_valid, .stage_valid, .line_done, .line_enable);
  mem_model mem_u (.mclk, .rst_n, .lat, .fetch_req, .fetch_addr, .fetch_ack, .fetch_data);
  // ------------------------------
  // Tasks
  // ------------------------------
  task stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int k;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= dat;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k == 16) begin failures++; stop_test(); end
  endtask
  task tick(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask
  task pulse_sup(input logic boot);
    apb(1'b1, SEQ_CTRL_OFF, 32'h0);
    tick(4);
    chk("user mode", supervisor_mode, 0);
    @(posedge mclk);
    if (boot) boot_done <= 1'b1; else irq_entry <= 1'b1;
    @(posedge mclk);
    boot_done <= 1'b0; irq_entry <= 1'b0;
    tick(2);
    chk("forced supervisor", supervisor_mode, 1);
  endtask
  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    mclk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    boot_done = 0; irq_entry = 0; stall = 1; pin_in = 4'ha; lat = 3'h0;
    failures = 0; check_count = 0; dn = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, SEQ_CTRL_OFF, 32'h0); chk("ctrl reset", q, CTRL_RESET);
    apb(1'b1, SEQ_CTRL_OFF, 32'h7fffffff);
    apb(1'b0, SEQ_CTRL_OFF, 32'h0); chk("ctrl mask", q, 32'h7fffffff & CTRL_WMASK);
    chk("buf ctrl", {30'h0, branch_buffer_lock, branch_buffer_enable}, 32'h3);
    for (n = 0; n < 4; n++) begin
      d = {4'h0, 4'h5 ^ 4'(n), 4'(3 * n), 4'(n + 9), 11'h0, 2'(n), 3'h0};
      apb(1'b1, SEQ_CTRL_OFF, d);
      tick(3);
      chk("timers", {30'h0, timer_run}, {30'h0, d[4:3]});
      chk("sense", {28'h0, irq_level_sense}, {28'h0, d[19:16]});
      chk("pin dir", {28'h0, pin_oe}, {28'h0, d[23:20]});
      chk("pin out", {28'h0, pin_out}, {28'h0, d[27:24] & d[23:20]});
      apb(1'b0, SEQ_STATUS_OFF, 32'h0);
      chk("pin in", {28'h0, q[19:16]}, {28'h0, pin_in & ~d[23:20]});
    end
    apb(1'b1, SEQ_CTRL_OFF, 32'h1);
    tick(1); chk("mode early", supervisor_mode, 0);
    tick(2); chk("mode late", supervisor_mode, 1);
    pulse_sup(1'b0);
    pulse_sup(1'b1);
    apb(1'b0, 8'h20, 32'h0); chk("unmapped err", err, 1); chk("unmapped data", q, 0);
    for (m = 0; m < 2; m++) begin
      if (m == 1) begin
        apb(1'b1, STATIC_FLAG_OFF, 32'h4);
        apb(1'b1, PIPE_CMD_OFF, 32'h42);
        apb(1'b0, STATIC_FLAG_OFF, 32'h0); chk("static flags", q, 32'h4);
        apb(1'b0, PIPE_CMD_OFF, 32'h0); chk("pred sel", q, 32'h42);
      end
      pe = (m == 1);
      @(posedge mclk); stall <= 1'b0; lat <= 3'(4 * m);
      for (n = 0; n < 300 && dn < 4; n++) begin
        @(negedge mclk);
        if (line_valid === 1'b1) begin
          chk("line size", {29'h0, line_count}, 32'h2);
          chk("line end", {31'h0, line_slots[63]}, 32'h1);
          chk("line enable", {31'h0, line_enable}, {31'h0, !line_slots[30] || pe});
        end
        if (line_done === 1'b1) dn++;
      end
      chk("lines done", dn, 4);
      dn = 0;
      @(posedge mclk); stall <= 1'b1;
    end
    apb(1'b1, SEQ_CTRL_OFF, 32'h80000011);
    for (n = 0; n < 20 && core_reset !== 1'b1; n++) @(negedge mclk);
    chk("soft reset", core_reset, 1);
    tick(10);
    apb(1'b0, SEQ_CTRL_OFF, 32'h0); chk("ctrl kept", q, 32'h11);
    stop_test();
  end
endmodule
`default_nettype wire
